// File: rtl/adc_output_format_consts.vh
// Purpose: constants for the converter output format and overrange register bank
// Assumes: 12-bit control port addresses, 8-bit register data
// Notes: register offsets are the control port addresses
//
// What this block does
// - eight overrange clear bits, bit n holds virtual converter n's flag cleared.
// - all overrange clear bits reset to zero, so every flag is enabled.
// - status bit n sets on an overrange of converter n; resets to zero.
// - overrange status register is read only; writes leave flags unchanged.
// - user pattern words 2, 3, 4 as low/high 8-bit registers, reset zero.
// - 3-bit selector picks status bit: low, overrange, monitor, fast detect, sysref.
// - output mode bit 2 inverts output samples when set; resets to zero.
// - format bits [1:0]: 00 offset binary, 01 twos complement; reset 0x01.
// - channel select bit 0 swaps the two channels when set; resets to zero.
// - user pattern repeats when selection bit is 0, plays once when 1.
`ifndef ADC_OUTPUT_FORMAT_CONSTS_VH
`define ADC_OUTPUT_FORMAT_CONSTS_VH

`define ADDR_W 12
`define SAMPLE_W 14
`define VCONV_N 8

`define ADDR_PATTERN_TWO_LOW 12'h553
`define ADDR_PATTERN_TWO_HIGH 12'h554
`define ADDR_PATTERN_THREE_LOW 12'h555
`define ADDR_PATTERN_THREE_HIGH 12'h556
`define ADDR_PATTERN_FOUR_LOW 12'h557
`define ADDR_PATTERN_FOUR_HIGH 12'h558
`define ADDR_STATUS_SOURCE 12'h559
`define ADDR_SAMPLE_FORMAT 12'h561
`define ADDR_OR_CLEAR 12'h562
`define ADDR_OR_STATUS 12'h563
`define ADDR_CHANNEL_ORDER 12'h564

`define RESET_PATTERN 8'h00
`define RESET_STATUS_SOURCE 8'h00
`define RESET_SAMPLE_FORMAT 8'h01
`define RESET_OR_CLEAR 8'h00
`define RESET_OR_STATUS 8'h00
`define RESET_CHANNEL_ORDER 8'h00

`define INVERT_BIT 2
`define SWAP_BIT 0

`define FMT_OFFSET_BINARY 2'h0
`define FMT_TWOS_COMP 2'h1

`define STAT_TIE_LOW 3'h0
`define STAT_OVERRANGE 3'h1
`define STAT_SIGNAL_MONITOR 3'h2
`define STAT_FAST_DETECT 3'h3
`define STAT_NOT_APPLICABLE 3'h4
`define STAT_SYSREF 3'h5

`define PATTERN_COUNT 2'h3

`endif

// File: rtl/two_entry_buffer.v
// Purpose: two-entry valid/ready buffer in the sample path
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; in_ready drops when both entries hold data
`timescale 1ns/100ps
module two_entry_buffer #(
    parameter WIDTH = 29
) (
    input wire mclk,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] count_reg;
    reg [1:0] count_next;
    wire push;
    wire pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @* begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            count_reg <= count_next;
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
        end
    end

    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule // two_entry_buffer

// File: rtl/adc_output_format_and_overrange.v
// Purpose: output format stage and overrange flags of a dual converter
// Assumes: inputs synchronous to mclk; samples arrive as twos complement
// Notes: register reads answer one cycle after reg_rd with reg_rdata
`timescale 1ns/100ps
`include "adc_output_format_consts.vh"
module adc_output_format_and_overrange (
    input wire mclk,
    input wire reset,
    // control port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rdata_valid,
    // test mode controls kept by neighbouring registers
    input wire pattern_mode_enable,
    input wire pattern_single,
    input wire [15:0] user_pattern_one,
    // converter sample input
    input wire in_valid,
    output wire in_ready,
    input wire [`SAMPLE_W-1:0] in_sample_a,
    input wire [`SAMPLE_W-1:0] in_sample_b,
    input wire in_overrange,
    input wire [`VCONV_N-1:0] vconv_overrange,
    input wire signal_monitor_bit,
    input wire fast_detect_flag,
    input wire sysref_bit,
    // formatted sample output
    output wire out_valid,
    input wire out_ready,
    output wire [`SAMPLE_W-1:0] out_sample_a,
    output wire [`SAMPLE_W-1:0] out_sample_b,
    output wire out_status
);
    localparam BUF_W = 2 * `SAMPLE_W + 1;

    reg [7:0] pattern_two_low_reg;
    reg [7:0] pattern_two_high_reg;
    reg [7:0] pattern_three_low_reg;
    reg [7:0] pattern_three_high_reg;
    reg [7:0] pattern_four_low_reg;
    reg [7:0] pattern_four_high_reg;
    reg [7:0] status_source_reg;
    reg [7:0] sample_format_reg;
    reg [7:0] or_clear_reg;
    reg [7:0] channel_order_reg;
    wire [`VCONV_N-1:0] or_status;

    reg [1:0] pattern_idx_reg;
    reg pattern_done_reg;
    reg [15:0] pattern_word;
    reg [`SAMPLE_W-1:0] raw_a;
    reg [`SAMPLE_W-1:0] raw_b;
    reg [`SAMPLE_W-1:0] fmt_a;
    reg [`SAMPLE_W-1:0] fmt_b;
    reg status_sel;
    wire accept;
    wire buf_in_ready;
    wire [BUF_W-1:0] buf_in;
    wire [BUF_W-1:0] buf_out;

    // applies number format then inversion to one sample
    // offset binary differs from twos complement only in the sign bit
    function [`SAMPLE_W-1:0] format_sample;
        input [`SAMPLE_W-1:0] s;
        input [1:0] fmt;
        input inv;
        reg [`SAMPLE_W-1:0] t;
        begin
            t = s;
            if (fmt == `FMT_OFFSET_BINARY) begin
                t[`SAMPLE_W-1] = ~s[`SAMPLE_W-1];
            end
            format_sample = inv ? ~t : t;
        end
    endfunction

    // register write side
    // narrow control registers keep only their implemented bits
    always @(posedge mclk) begin
        if (reset) begin
            pattern_two_low_reg <= `RESET_PATTERN;
            pattern_two_high_reg <= `RESET_PATTERN;
            pattern_three_low_reg <= `RESET_PATTERN;
            pattern_three_high_reg <= `RESET_PATTERN;
            pattern_four_low_reg <= `RESET_PATTERN;
            pattern_four_high_reg <= `RESET_PATTERN;
            status_source_reg <= `RESET_STATUS_SOURCE;
            sample_format_reg <= `RESET_SAMPLE_FORMAT;
            or_clear_reg <= `RESET_OR_CLEAR;
            channel_order_reg <= `RESET_CHANNEL_ORDER;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_PATTERN_TWO_LOW: begin
                    pattern_two_low_reg <= reg_wdata;
                end
                `ADDR_PATTERN_TWO_HIGH: begin
                    pattern_two_high_reg <= reg_wdata;
                end
                `ADDR_PATTERN_THREE_LOW: begin
                    pattern_three_low_reg <= reg_wdata;
                end
                `ADDR_PATTERN_THREE_HIGH: begin
                    pattern_three_high_reg <= reg_wdata;
                end
                `ADDR_PATTERN_FOUR_LOW: begin
                    pattern_four_low_reg <= reg_wdata;
                end
                `ADDR_PATTERN_FOUR_HIGH: begin
                    pattern_four_high_reg <= reg_wdata;
                end
                `ADDR_STATUS_SOURCE: begin
                    status_source_reg <= {5'h00, reg_wdata[2:0]};
                end
                `ADDR_SAMPLE_FORMAT: begin
                    sample_format_reg <= {5'h00, reg_wdata[2:0]};
                end
                `ADDR_OR_CLEAR: begin
                    or_clear_reg <= reg_wdata;
                end
                `ADDR_CHANNEL_ORDER: begin
                    channel_order_reg <= {7'h00, reg_wdata[0]};
                end
                default: begin
                    // status register and unmapped addresses take no write
                end
            endcase
        end
    end

    // one sticky flag per virtual converter; the clear bit is a hold, not a pulse
    genvar gi;
    generate
        for (gi = 0; gi < `VCONV_N; gi = gi + 1) begin : g_or_flag
            reg flag_reg;
            always @(posedge mclk) begin
                if (reset) begin
                    flag_reg <= 1'b0;
                // clear is tested first, so it beats an event in the same cycle
                end else if (or_clear_reg[gi]) begin
                    flag_reg <= 1'b0;
                end else if (vconv_overrange[gi]) begin
                    flag_reg <= 1'b1;
                end
            end
            assign or_status[gi] = flag_reg;
        end
    endgenerate

    // register read side
    // read data is registered; the valid strobe marks the cycle after the request
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_PATTERN_TWO_LOW: begin
                        reg_rdata <= pattern_two_low_reg;
                    end
                    `ADDR_PATTERN_TWO_HIGH: begin
                        reg_rdata <= pattern_two_high_reg;
                    end
                    `ADDR_PATTERN_THREE_LOW: begin
                        reg_rdata <= pattern_three_low_reg;
                    end
                    `ADDR_PATTERN_THREE_HIGH: begin
                        reg_rdata <= pattern_three_high_reg;
                    end
                    `ADDR_PATTERN_FOUR_LOW: begin
                        reg_rdata <= pattern_four_low_reg;
                    end
                    `ADDR_PATTERN_FOUR_HIGH: begin
                        reg_rdata <= pattern_four_high_reg;
                    end
                    `ADDR_STATUS_SOURCE: begin
                        reg_rdata <= status_source_reg;
                    end
                    `ADDR_SAMPLE_FORMAT: begin
                        reg_rdata <= sample_format_reg;
                    end
                    `ADDR_OR_CLEAR: begin
                        reg_rdata <= or_clear_reg;
                    end
                    `ADDR_OR_STATUS: begin
                        reg_rdata <= or_status;
                    end
                    `ADDR_CHANNEL_ORDER: begin
                        reg_rdata <= channel_order_reg;
                    end
                    default: begin
                        // unmapped addresses read as zero
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // user pattern sequencer, steps one word per accepted sample pair
    assign accept = in_valid && buf_in_ready;

    always @(posedge mclk) begin
        // leaving test mode rewinds the sequence to word one
        if (reset || !pattern_mode_enable) begin
            pattern_idx_reg <= 2'h0;
            pattern_done_reg <= 1'b0;
        end else if (accept && !pattern_done_reg) begin
            pattern_idx_reg <= pattern_idx_reg + 2'h1;
            // single mode stops after word four and sends zero words from then on
            if (pattern_idx_reg == `PATTERN_COUNT && pattern_single) begin
                pattern_done_reg <= 1'b1;
            end
        end
    end

    // word one is kept by a neighbouring register and arrives on a port
    always @* begin
        case (pattern_idx_reg)
            2'h0: begin
                pattern_word = user_pattern_one;
            end
            2'h1: begin
                pattern_word = {pattern_two_high_reg, pattern_two_low_reg};
            end
            2'h2: begin
                pattern_word = {pattern_three_high_reg, pattern_three_low_reg};
            end
            default: begin
                pattern_word = {pattern_four_high_reg, pattern_four_low_reg};
            end
        endcase
        if (pattern_done_reg) begin
            pattern_word = 16'h0000;
        end
    end

    // sample path: select source, swap, format
    // test patterns bypass the swap, so both channels carry the same word
    always @* begin
        if (pattern_mode_enable) begin
            raw_a = pattern_word[15:16-`SAMPLE_W];
            raw_b = pattern_word[15:16-`SAMPLE_W];
        end else if (channel_order_reg[`SWAP_BIT]) begin
            raw_a = in_sample_b;
            raw_b = in_sample_a;
        end else begin
            raw_a = in_sample_a;
            raw_b = in_sample_b;
        end
        fmt_a = format_sample(raw_a, sample_format_reg[1:0], sample_format_reg[`INVERT_BIT]);
        fmt_b = format_sample(raw_b, sample_format_reg[1:0], sample_format_reg[`INVERT_BIT]);
    end

    always @* begin
        case (status_source_reg[2:0])
            `STAT_TIE_LOW: begin
                status_sel = 1'b0;
            end
            `STAT_OVERRANGE: begin
                status_sel = in_overrange;
            end
            `STAT_SIGNAL_MONITOR: begin
                status_sel = signal_monitor_bit;
            end
            `STAT_FAST_DETECT: begin
                status_sel = fast_detect_flag;
            end
            `STAT_SYSREF: begin
                status_sel = sysref_bit;
            end
            default: begin
                // codes with no source, not-applicable included, give a low bit
                status_sel = 1'b0;
            end
        endcase
    end

    // the buffer alone decides when input is taken
    assign in_ready = buf_in_ready;

    // status bit travels with its sample pair so a stall cannot separate them
    assign buf_in = {status_sel, fmt_b, fmt_a};

    // two words of slack so a receiver stall never drops a sample
    two_entry_buffer #(
        .WIDTH(BUF_W)
    ) u_buffer (
        .mclk(mclk),
        .reset(reset),
        .in_valid(in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    assign out_sample_a = buf_out[`SAMPLE_W-1:0];
    assign out_sample_b = buf_out[2*`SAMPLE_W-1:`SAMPLE_W];
    assign out_status = buf_out[BUF_W-1];
endmodule // adc_output_format_and_overrange

// File: verification/adc_output_format_checker.sv
// Purpose: port-level assertions for the output format and overrange bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: clr_reg mirrors the overrange clear register from port writes
`timescale 1ns/100ps
`include "adc_output_format_consts.vh"
module adc_output_format_checker (
    input wire mclk,
    input wire reset,
    input wire [`ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rdata_valid,
    input wire [`VCONV_N-1:0] vconv_overrange,
    input wire out_valid,
    input wire out_ready,
    input wire [`SAMPLE_W-1:0] out_sample_a,
    input wire [`SAMPLE_W-1:0] out_sample_b,
    input wire out_status
);
    reg [7:0] clr_reg;
    wire wr_clear = reg_wr && reg_addr == `ADDR_OR_CLEAR;
    wire [7:0] ev_w = vconv_overrange & ~clr_reg;
    wire full_rw = (reg_addr >= 12'h553 && reg_addr <= 12'h558) || reg_addr == `ADDR_OR_CLEAR;
    wire [7:0] mask_w = (reg_addr == 12'h559 || reg_addr == 12'h561) ? 8'h07 : {7'h00, reg_addr == 12'h564};
    always @(posedge mclk) begin
        if (reset)
            clr_reg <= 8'h00;
        else if (wr_clear)
            clr_reg <= reg_wdata;
    end
    sequence s_rd_status;
        reg_rd && !reg_wr && reg_addr == `ADDR_OR_STATUS;
    endsequence
    sequence s_idle_same;
        !reg_wr && $stable(reg_addr);
    endsequence
    sequence s_rd_same;
        reg_rd && !reg_wr && $stable(reg_addr);
    endsequence
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_reset_defaults: assert property (reg_rd && $past(reset) |=> reg_rdata == {7'h00, $past(reg_addr) == 12'h561})
        else $error("register not at reset value");
    a_rw_readback: assert property ((reg_wr && full_rw) ##1 s_idle_same ##1 s_rd_same |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("register readback differs");
    a_masked_readback: assert property ((reg_wr && mask_w != 8'h00) ##1 s_idle_same ##1 s_rd_same |=>
        reg_rdata == ($past(reg_wdata, 3) & $past(mask_w, 3))) else $error("control field readback differs");
    a_flag_sets: assert property ((ev_w != 8'h00 && !wr_clear) ##1 s_rd_status |=>
        (reg_rdata & $past(ev_w, 2)) == $past(ev_w, 2)) else $error("overrange flag not recorded");
    a_clear_wins: assert property ((wr_clear && reg_wdata == 8'hff) ##1 !reg_wr ##1 s_rd_status |=> reg_rdata == 8'h00)
        else $error("cleared flags still set");
    a_status_read_only: assert property ((s_rd_status and vconv_overrange == 8'h00) ##1
        (reg_wr && !reg_rd && reg_addr == `ADDR_OR_STATUS && vconv_overrange == 8'h00) ##1 s_rd_status
        |=> reg_rdata == $past(reg_rdata, 2)) else $error("status write changed flags");
    a_read_latency: assert property (1'b1 |=> reg_rdata_valid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    a_output_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample_a) &&
        $stable(out_sample_b) && $stable(out_status)) else $error("stalled output word changed");
endmodule // adc_output_format_checker

bind adc_output_format_and_overrange adc_output_format_checker adc_output_format_checker_inst (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .vconv_overrange(vconv_overrange),
    .out_valid(out_valid), .out_ready(out_ready), .out_sample_a(out_sample_a), .out_sample_b(out_sample_b),
    .out_status(out_status));

// File: verification/sample_receiver.sv
// Purpose: receiving logic that captures formatted sample words
// Assumes: stall from the bench holds ready low
// Notes: got pulses one cycle per captured word
`timescale 1ns/100ps
module sample_receiver (
    input wire mclk,
    input wire reset,
    input wire stall,
    input wire out_valid,
    output wire out_ready,
    input wire [13:0] out_sample_a,
    input wire [13:0] out_sample_b,
    input wire out_status,
    output reg got,
    output reg [28:0] got_word
);
    assign out_ready = !stall;
    always @(posedge mclk) begin
        got <= !reset && out_valid && out_ready;
        if (out_valid && out_ready)
            got_word <= {out_sample_a, out_sample_b, out_status};
    end
endmodule // sample_receiver

// File: verification/adc_output_format_and_overrange_test.sv
// Purpose: self-checking bench for the output format and overrange bank
// Assumes: receiver model captures every output word
// Notes: row table holds hand-worked output words
`timescale 1ns/100ps
`include "adc_output_format_consts.vh"
module adc_output_format_and_overrange_test;
    reg mclk, reset, reg_wr, reg_rd, pattern_mode_enable, pattern_single, in_valid, stall;
    reg in_overrange, signal_monitor_bit, fast_detect_flag, sysref_bit;
    reg [11:0] reg_addr;
    reg [7:0] reg_wdata, vconv_overrange;
    reg [15:0] user_pattern_one;
    reg [13:0] in_sample_a, in_sample_b;
    wire [7:0] reg_rdata;
    wire reg_rdata_valid, in_ready, out_valid, out_ready, out_status, got;
    wire [13:0] out_sample_a, out_sample_b;
    wire [28:0] got_word;
    reg [28:0] q[$];
    reg [87:0] rows [0:7];
    reg [13:0] pw [0:4];
    reg [87:0] r;
    reg [11:0] a;
    integer failures, n_tests, cycles, i;

    adc_output_format_and_overrange adc_output_format_and_overrange_inst (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .pattern_mode_enable(pattern_mode_enable),
        .pattern_single(pattern_single), .user_pattern_one(user_pattern_one), .in_valid(in_valid),
        .in_ready(in_ready), .in_sample_a(in_sample_a), .in_sample_b(in_sample_b), .in_overrange(in_overrange),
        .vconv_overrange(vconv_overrange), .signal_monitor_bit(signal_monitor_bit),
        .fast_detect_flag(fast_detect_flag), .sysref_bit(sysref_bit), .out_valid(out_valid),
        .out_ready(out_ready), .out_sample_a(out_sample_a), .out_sample_b(out_sample_b), .out_status(out_status));
    sample_receiver sample_receiver_inst (.mclk(mclk), .reset(reset), .stall(stall), .out_valid(out_valid),
        .out_ready(out_ready), .out_sample_a(out_sample_a), .out_sample_b(out_sample_b),
        .out_status(out_status), .got(got), .got_word(got_word));

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input string name, input [28:0] e, input [28:0] s);
        begin
            n_tests = n_tests + 1;
            if (s !== e) begin
                failures = failures + 1;
                $display("[FAIL] %s expected %h seen %h", name, e, s);
            end
        end
    endtask
    task wr(input [11:0] ad, input [7:0] d);
        begin
            reg_addr <= ad;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task rd(input [11:0] ad, input [7:0] e);
        begin
            reg_addr <= ad;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(negedge mclk);
            check("reg_rdata", {21'h0, e}, {21'h0, reg_rdata});
            @(posedge mclk);
        end
    endtask
    task pulse(input [7:0] v);
        begin
            vconv_overrange <= v;
            @(posedge mclk);
            vconv_overrange <= 8'h00;
        end
    endtask
    task send(input [13:0] sa, input [13:0] sb);
        reg ok;
        begin
            in_valid <= 1'b1;
            in_sample_a <= sa;
            in_sample_b <= sb;
            ok = 1'b0;
            while (!ok) begin
                @(negedge mclk);
                ok = (in_ready === 1'b1);
                @(posedge mclk);
            end
            in_valid <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task take(input [28:0] e);
        integer k;
        begin
            for (k = 0; k < 100 && q.size() == 0; k = k + 1)
                @(posedge mclk);
            check("word", e, q.size() > 0 ? q.pop_front() : 29'bx);
        end
    endtask
    function [7:0] expv(input [11:0] ad, input [7:0] d);
        begin
            if ((ad >= 12'h553 && ad <= 12'h558) || ad == 12'h562)
                expv = d;
            else if (ad == 12'h559 || ad == 12'h561)
                expv = d & 8'h07;
            else
                expv = (ad == 12'h564) ? (d & 8'h01) : 8'h00;
        end
    endfunction

    always @(posedge mclk) begin
        if (got)
            q.push_back(got_word);
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        {reset, reg_wr, reg_rd, pattern_mode_enable, pattern_single, in_valid, stall} = 7'h40;
        {in_overrange, signal_monitor_bit, fast_detect_flag, sysref_bit} = 4'h0;
        {reg_addr, reg_wdata, vconv_overrange, in_sample_a, in_sample_b} = 56'h0;
        user_pattern_one = 16'h0abc;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        // {fmt, swap, sel, {sysref, fd, mon, or}, status, a, b, out a, out b}
        rows[0] = 88'h01_0_0_f_0_0123_3f00_0123_3f00;
        rows[1] = 88'h00_0_1_1_1_0123_3f00_2123_1f00;
        rows[2] = 88'h04_0_2_2_1_0123_3f00_1edc_20ff;
        rows[3] = 88'h05_1_3_4_1_0123_3f00_00ff_3edc;
        rows[4] = 88'h01_0_5_8_1_0123_3f00_0123_3f00;
        rows[5] = 88'h01_0_4_f_0_0123_3f00_0123_3f00;
        rows[6] = 88'h01_0_3_b_0_0123_3f00_0123_3f00;
        rows[7] = 88'h01_0_7_f_0_0123_3f00_0123_3f00;
        pw[0] = 14'h02af;
        pw[1] = 14'h048d;
        pw[2] = 14'h3fff;
        pw[3] = 14'h2001;
        pw[4] = 14'h02af;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        for (a = 12'h553; a <= 12'h564; a = a + 1)
            rd(a, {7'h00, a == 12'h561});
        for (a = 12'h553; a <= 12'h564; a = a + 1) begin
            wr(a, a[7:0] ^ 8'hff);
            rd(a, expv(a, a[7:0] ^ 8'hff));
        end
        wr(12'h562, 8'h00);
        pulse(8'hff);
        rd(12'h563, 8'hff);
        wr(12'h562, 8'hff);
        rd(12'h563, 8'h00);
        wr(12'h562, 8'h00);
        pulse(8'h5a);
        rd(12'h563, 8'h5a);
        reg_addr <= 12'h563;
        reg_rd <= 1'b1;
        @(posedge mclk);
        {reg_rd, reg_wr, reg_wdata} <= 10'h1ff;
        @(posedge mclk);
        {reg_rd, reg_wr} <= 2'h2;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check("status after write", 29'h5a, {21'h0, reg_rdata});
        @(posedge mclk);
        wr(12'h562, 8'h0f);
        pulse(8'hff);
        rd(12'h563, 8'hf0);
        wr(12'h562, 8'h00);
        pulse(8'h01);
        rd(12'h563, 8'hf1);
        for (i = 0; i < 8; i = i + 1) begin
            r = rows[i];
            wr(`ADDR_SAMPLE_FORMAT, r[87:80]);
            wr(`ADDR_CHANNEL_ORDER, {7'h00, r[76]});
            wr(`ADDR_STATUS_SOURCE, {4'h0, r[75:72]});
            {sysref_bit, fast_detect_flag, signal_monitor_bit, in_overrange} <= r[71:68];
            send(r[61:48], r[45:32]);
            take({r[29:16], r[13:0], r[64]});
        end
        for (i = 0; i < 6; i = i + 1)
            wr(12'h553 + i, i[0] ? (i[2:1] == 2'h0 ? 8'h12 : (i[2:1] == 2'h1 ? 8'hff : 8'h80)) :
                (i[2:1] == 2'h0 ? 8'h34 : (i[2:1] == 2'h1 ? 8'hfc : 8'h04)));
        pattern_mode_enable <= 1'b1;
        stall <= 1'b1;
        send(14'h0, 14'h0);
        send(14'h0, 14'h0);
        @(negedge mclk);
        check("in_ready full", 29'h0, {28'h0, in_ready});
        repeat (5) @(posedge mclk);
        stall <= 1'b0;
        for (i = 0; i < 3; i = i + 1)
            send(14'h0, 14'h0);
        for (i = 0; i < 5; i = i + 1)
            take({pw[i], pw[i], 1'b0});
        pattern_mode_enable <= 1'b0;
        @(posedge mclk);
        pattern_mode_enable <= 1'b1;
        pattern_single <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
            send(14'h0, 14'h0);
        for (i = 0; i < 5; i = i + 1)
            take(i < 4 ? {pw[i], pw[i], 1'b0} : 29'h0);
        wr(`ADDR_SAMPLE_FORMAT, 8'h06);
        wr(`ADDR_OR_CLEAR, 8'h3c);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(`ADDR_SAMPLE_FORMAT, `RESET_SAMPLE_FORMAT);
        rd(`ADDR_OR_CLEAR, `RESET_OR_CLEAR);
        rd(`ADDR_OR_STATUS, `RESET_OR_STATUS);
        tally_and_finish;
    end
endmodule // adc_output_format_and_overrange_test
